//--- include/starter_sup_params.svh
// Constants for the starter supervisory logic
`ifndef STARTER_SUP_PARAMS_SVH
`define STARTER_SUP_PARAMS_SVH

// Timing
`define CLK_PERIOD_NS     4
`define SEC_PERIOD_NS     1000000000
`define SEC_CYCLES        (`SEC_PERIOD_NS / `CLK_PERIOD_NS)

// Request timeout setting
`define TMO_OFF           7'h00
`define TMO_MAX_SEC       7'h78
`define TMO_RST           7'h00

// Station address setting
`define STA_MIN           8'h01
`define STA_MAX           8'hf7
`define STA_RST           8'h01

// Fault and event codes
`define LINK_TMO_CODE     8'h52
`define EVT_STATE_TAG     4'h8

// Log depths
`define FAULT_DEPTH       9
`define EVENT_DEPTH       99

// Passcode
`define LOCK_DIGITS       3'h4
`define DIGIT_MAX         4'h9

`endif

//--- include/starter_sup_pkg.sv
// Types for the starter supervisory logic
package starter_sup_pkg;

  typedef enum logic [1:0] {
    FRAME_EVEN_1, FRAME_ODD_1, FRAME_NONE_1, FRAME_NONE_2
  } framing_e;

  typedef enum logic [2:0] {
    RATE_1200, RATE_2400, RATE_4800, RATE_9600, RATE_19200
  } bit_rate_e;

  typedef enum logic [2:0] {
    FMT_MDY_12, FMT_MDY_24, FMT_YMD_12, FMT_YMD_24, FMT_DMY_12, FMT_DMY_24
  } time_fmt_e;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_CLEAR_RUN_TIME, CMD_CLEAR_ENERGY, CMD_UPDATE_MODE,
    CMD_STORE, CMD_LOAD, CMD_FACTORY, CMD_UNPOWERED_TEST, CMD_POWERED_TEST
  } maint_cmd_e;

  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] snapshot;
  } fault_rec_s;

  typedef struct packed {
    logic [7:0]  code;
    logic [3:0]  state;
    logic [23:0] tod;
    logic [23:0] date;
  } event_rec_s;

endpackage

//--- design/history_log.sv
// Newest-first history log held in flip-flops
`timescale 1ns/1ns
module history_log #(
  parameter int DEPTH = 9,
  parameter int WIDTH = 24,
  parameter int IDXW  = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Write side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  // Read side
  input  wire logic [IDXW-1:0]  rd_idx,
  output logic      [WIDTH-1:0] rd_data,
  output logic      [IDXW-1:0]  fill
);

  logic [WIDTH-1:0] entry_ff [DEPTH];
  logic [IDXW-1:0]  fill_ff;
  wire              idx_ok = (int'(rd_idx) < DEPTH);

  // Entry zero takes the new record; everything else ages by one slot
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_slot
      always_ff @(posedge core_clk) begin
        if (rst)
          entry_ff[i] <= '0;
        else if (push)
          entry_ff[i] <= (i == 0) ? push_data : entry_ff[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst)
      fill_ff <= '0;
    else if (push && (int'(fill_ff) < DEPTH))
      fill_ff <= fill_ff + 1'b1;
  end

  assign rd_data = idx_ok ? entry_ff[idx_ok ? rd_idx : '0] : '0;
  assign fill    = fill_ff;

endmodule // history_log

//--- design/starter_supervisor.sv
// Starter supervisory logic: link watchdog, settings, commands, lock and logs
`timescale 1ns/1ns
`include "starter_sup_params.svh"
module starter_supervisor #(
  parameter int SEC_CYCLES = `SEC_CYCLES
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // Serial link settings and request report
  input  wire logic [6:0]                request_timeout_setting,
  input  wire logic [1:0]                byte_framing_setting,
  input  wire logic [7:0]                station_address_setting,
  input  wire logic [2:0]                bit_rate_setting,
  input  wire logic                      rx_request_valid,
  input  wire logic [7:0]                rx_request_addr,
  output logic                           rx_request_accept_ff,
  output starter_sup_pkg::framing_e      framing_ff,
  output logic [7:0]                     station_ff,
  output starter_sup_pkg::bit_rate_e     bit_rate_ff,
  // Link fault
  input  wire logic                      fault_reset,
  output logic                           link_timeout_fault_ff,
  output logic                           controlled_stop_req_ff,
  // Maintenance commands
  input  wire logic                      maint_cmd_write,
  input  wire logic [3:0]                maintenance_command_select,
  input  wire logic                      motor_idle,
  input  wire logic                      medium_voltage,
  output starter_sup_pkg::maint_cmd_e    maint_sel_ff,
  output logic                           clear_run_time_meter_ff,
  output logic                           clear_energy_meters_ff,
  output logic                           store_params_ff,
  output logic                           load_params_ff,
  output logic                           factory_defaults_ff,
  output logic                           unpowered_self_test_ff,
  output logic                           line_powered_self_test_ff,
  output logic                           cmd_refused_ff,
  output logic                           update_mode_indication_ff,
  output logic                           remote_display_enable_ff,
  output logic                           normal_operation_ff,
  // Time and date
  input  wire logic [2:0]                time_date_format_setting,
  input  wire logic [23:0]               tod_hms,
  input  wire logic [23:0]               date_value,
  output starter_sup_pkg::time_fmt_e     time_fmt_ff,
  // Parameter lock
  input  wire logic                      lock_digit_valid,
  input  wire logic [3:0]                parameter_lock_code,
  input  wire logic                      edit_inc,
  input  wire logic                      edit_dec,
  output logic                           lock_status_ff,
  output logic                           edit_inc_ok_ff,
  output logic                           edit_dec_ok_ff,
  // Fault and event history
  input  wire logic                      fault_valid,
  input  wire logic [7:0]                fault_code,
  input  wire logic [15:0]               fault_snapshot,
  input  wire logic [3:0]                starter_state,
  input  wire logic [3:0]                fault_rd_idx,
  input  wire logic [6:0]                event_rd_idx,
  output starter_sup_pkg::fault_rec_s    fault_rd_ff,
  output starter_sup_pkg::event_rec_s    event_rd_ff,
  output logic [3:0]                     fault_fill_ff,
  output logic [6:0]                     event_fill_ff
);

  // Station, bit rate and format settings that are out of range are ignored and the old value kept
  wire sta_ok   = (station_address_setting >= `STA_MIN) &&
                  (station_address_setting <= `STA_MAX);
  wire rate_ok  = (bit_rate_setting <= 3'(starter_sup_pkg::RATE_19200));
  wire fmt_ok   = (time_date_format_setting <= 3'(starter_sup_pkg::FMT_DMY_24));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      framing_ff  <= starter_sup_pkg::FRAME_EVEN_1;
      station_ff  <= `STA_RST;
      bit_rate_ff <= starter_sup_pkg::RATE_19200;
      time_fmt_ff <= starter_sup_pkg::FMT_MDY_12;
    end else begin
      framing_ff <= starter_sup_pkg::framing_e'(byte_framing_setting);
      if (sta_ok)
        station_ff <= station_address_setting;
      if (rate_ok)
        bit_rate_ff <= starter_sup_pkg::bit_rate_e'(bit_rate_setting);
      if (fmt_ok)
        time_fmt_ff <= starter_sup_pkg::time_fmt_e'(time_date_format_setting);
    end
  end

  // Link watchdog
  logic [31:0] sec_cnt_ff;
  logic [6:0]  tmo_sec_ff;
  logic        update_mode_ff;
  wire  [6:0]  tmo_limit = (request_timeout_setting > `TMO_MAX_SEC) ?
                           `TMO_MAX_SEC : request_timeout_setting;
  wire         tmo_on    = (tmo_limit != `TMO_OFF) && !update_mode_ff;
  wire         req_hit   = rx_request_valid && (rx_request_addr == station_ff);
  wire         sec_tick  = (sec_cnt_ff == 32'(SEC_CYCLES - 1));
  wire         tmo_clear = req_hit || !tmo_on;
  wire         tmo_fire  = tmo_on && !req_hit && sec_tick && !link_timeout_fault_ff &&
                           ((tmo_sec_ff + 7'h01) >= tmo_limit);

  always_ff @(posedge core_clk) begin
    if (rst || tmo_clear) begin
      sec_cnt_ff <= '0;
      tmo_sec_ff <= '0;
    end else begin
      sec_cnt_ff <= sec_tick ? '0 : sec_cnt_ff + 32'h1;
      if (sec_tick && (tmo_sec_ff < `TMO_MAX_SEC))
        tmo_sec_ff <= tmo_sec_ff + 7'h01;
    end
  end

  // Fault is sticky; a new timeout beats a reset in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link_timeout_fault_ff  <= 1'b0;
      controlled_stop_req_ff <= 1'b0;
      rx_request_accept_ff   <= 1'b0;
    end else begin
      rx_request_accept_ff <= req_hit && !update_mode_ff;
      if (tmo_fire) begin
        link_timeout_fault_ff  <= 1'b1;
        controlled_stop_req_ff <= 1'b1;
      end else if (fault_reset) begin
        link_timeout_fault_ff  <= 1'b0;
        controlled_stop_req_ff <= 1'b0;
      end
    end
  end

  // Maintenance selector: written, run once, then back to None
  wire is_none  = (maint_sel_ff == starter_sup_pkg::CMD_NONE);
  wire run_cmd  = !is_none && !update_mode_ff;
  wire upd_go   = run_cmd && (maint_sel_ff == starter_sup_pkg::CMD_UPDATE_MODE) && motor_idle;
  wire upd_nak  = run_cmd && (maint_sel_ff == starter_sup_pkg::CMD_UPDATE_MODE) && !motor_idle;
  wire pwr_go   = run_cmd && (maint_sel_ff == starter_sup_pkg::CMD_POWERED_TEST) &&
                  !medium_voltage;
  wire pwr_nak  = run_cmd && (maint_sel_ff == starter_sup_pkg::CMD_POWERED_TEST) &&
                  medium_voltage;
  wire cmd_ok   = (maintenance_command_select <= 4'(starter_sup_pkg::CMD_POWERED_TEST));

  always_ff @(posedge core_clk) begin
    if (rst)
      maint_sel_ff <= starter_sup_pkg::CMD_NONE;
    else if (!is_none)
      maint_sel_ff <= starter_sup_pkg::CMD_NONE;
    else if (maint_cmd_write && cmd_ok && !update_mode_ff)
      maint_sel_ff <= starter_sup_pkg::maint_cmd_e'(maintenance_command_select);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clear_run_time_meter_ff   <= 1'b0;
      clear_energy_meters_ff    <= 1'b0;
      store_params_ff           <= 1'b0;
      load_params_ff            <= 1'b0;
      factory_defaults_ff       <= 1'b0;
      unpowered_self_test_ff    <= 1'b0;
      line_powered_self_test_ff <= 1'b0;
      cmd_refused_ff            <= 1'b0;
    end else begin
      clear_run_time_meter_ff   <= run_cmd &&
        (maint_sel_ff == starter_sup_pkg::CMD_CLEAR_RUN_TIME);
      clear_energy_meters_ff    <= run_cmd &&
        (maint_sel_ff == starter_sup_pkg::CMD_CLEAR_ENERGY);
      store_params_ff           <= run_cmd && (maint_sel_ff == starter_sup_pkg::CMD_STORE);
      load_params_ff            <= run_cmd && (maint_sel_ff == starter_sup_pkg::CMD_LOAD);
      factory_defaults_ff       <= run_cmd &&
        (maint_sel_ff == starter_sup_pkg::CMD_FACTORY);
      unpowered_self_test_ff    <= run_cmd &&
        (maint_sel_ff == starter_sup_pkg::CMD_UNPOWERED_TEST);
      line_powered_self_test_ff <= pwr_go;
      cmd_refused_ff            <= upd_nak || pwr_nak;
    end
  end

  // Update mode latches until power is cycled, i.e. until the next reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      update_mode_ff            <= 1'b0;
      update_mode_indication_ff <= 1'b0;
      remote_display_enable_ff  <= 1'b1;
      normal_operation_ff       <= 1'b1;
    end else if (upd_go) begin
      update_mode_ff            <= 1'b1;
      update_mode_indication_ff <= 1'b1;
      remote_display_enable_ff  <= 1'b0;
      normal_operation_ff       <= 1'b0;
    end
  end

  // Passcode entry, one confirmed digit at a time
  logic [2:0]  digit_cnt_ff;
  logic [15:0] entry_ff;
  logic [15:0] code_ff;
  wire         digit_ok  = lock_digit_valid && (parameter_lock_code <= `DIGIT_MAX);
  wire         last_dig  = digit_ok && (digit_cnt_ff == (`LOCK_DIGITS - 3'h1));
  wire  [15:0] nxt_entry = {entry_ff[11:0], parameter_lock_code};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      digit_cnt_ff   <= '0;
      entry_ff       <= '0;
      code_ff        <= '0;
      lock_status_ff <= 1'b0;
    end else if (digit_ok) begin
      entry_ff     <= nxt_entry;
      digit_cnt_ff <= last_dig ? '0 : digit_cnt_ff + 3'h1;
      if (last_dig && !lock_status_ff) begin
        code_ff        <= nxt_entry;
        lock_status_ff <= 1'b1;
      end else if (last_dig && (nxt_entry == code_ff))
        lock_status_ff <= 1'b0;
    end
  end

  // Reads are never blocked; only the edit strobes are gated
  always_ff @(posedge core_clk) begin
    if (rst) begin
      edit_inc_ok_ff <= 1'b0;
      edit_dec_ok_ff <= 1'b0;
    end else begin
      edit_inc_ok_ff <= edit_inc && !lock_status_ff && normal_operation_ff;
      edit_dec_ok_ff <= edit_dec && !lock_status_ff && normal_operation_ff;
    end
  end

  // History logging
  logic       state_seen_ff;
  logic [3:0] prev_state_ff;
  wire        any_fault  = tmo_fire || fault_valid;
  wire  [7:0] fault_now  = tmo_fire ? `LINK_TMO_CODE : fault_code;
  wire        state_chg  = state_seen_ff && (starter_state != prev_state_ff);
  wire        evt_push   = any_fault || state_chg;
  starter_sup_pkg::fault_rec_s fault_new;
  starter_sup_pkg::event_rec_s event_new;
  starter_sup_pkg::fault_rec_s fault_rd;
  starter_sup_pkg::event_rec_s event_rd;
  logic [3:0] fault_fill;
  logic [6:0] event_fill;

  assign fault_new = '{code: fault_now, snapshot: tmo_fire ? '0 : fault_snapshot};
  // Time and date are stored as given; no seasonal shift is applied
  assign event_new = '{code:  any_fault ? fault_now : {`EVT_STATE_TAG, starter_state},
                       state: starter_state, tod: tod_hms, date: date_value};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_seen_ff <= 1'b0;
      prev_state_ff <= '0;
    end else begin
      state_seen_ff <= 1'b1;
      prev_state_ff <= starter_state;
    end
  end

  history_log #(.DEPTH(`FAULT_DEPTH), .WIDTH(24), .IDXW(4)) u_fault_log (
    .core_clk  (core_clk),
    .rst       (rst),
    .push      (any_fault),
    .push_data (fault_new),
    .rd_idx    (fault_rd_idx),
    .rd_data   (fault_rd),
    .fill      (fault_fill)
  );

  history_log #(.DEPTH(`EVENT_DEPTH), .WIDTH(60), .IDXW(7)) u_event_log (
    .core_clk  (core_clk),
    .rst       (rst),
    .push      (evt_push),
    .push_data (event_new),
    .rd_idx    (event_rd_idx),
    .rd_data   (event_rd),
    .fill      (event_fill)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_rd_ff   <= '0;
      event_rd_ff   <= '0;
      fault_fill_ff <= '0;
      event_fill_ff <= '0;
    end else begin
      fault_rd_ff   <= fault_rd;
      event_rd_ff   <= event_rd;
      fault_fill_ff <= fault_fill;
      event_fill_ff <= event_fill;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_cmd_loaded;
    maint_cmd_write && is_none && cmd_ok && !update_mode_ff &&
    (maintenance_command_select != 4'h0);
  endsequence

  chk_timeout_off_idle: assert property ((tmo_limit == `TMO_OFF) |=> (tmo_sec_ff == 7'h00))
    else $error("timeout count moved while Off");
  chk_fault_raise: assert property (tmo_fire |=> link_timeout_fault_ff && controlled_stop_req_ff)
    else $error("timeout did not raise fault and stop");
  chk_fault_hold: assert property (link_timeout_fault_ff && !fault_reset |=> link_timeout_fault_ff)
    else $error("link fault dropped without reset");
  chk_request_restart: assert property (req_hit |=> (tmo_sec_ff == 7'h00) && (sec_cnt_ff == 0))
    else $error("request did not restart watchdog");
  chk_sel_returns: assert property (s_cmd_loaded |=> !is_none ##1 is_none)
    else $error("selector did not return to None");
  chk_update_refused: assert property (upd_nak |=> cmd_refused_ff && !update_mode_ff)
    else $error("update mode entered while running");
  chk_update_display: assert property (update_mode_ff |-> update_mode_indication_ff &&
                                       !remote_display_enable_ff && !normal_operation_ff)
    else $error("update mode outputs wrong");
  chk_update_stays: assert property (update_mode_ff |=> update_mode_ff)
    else $error("update mode left without power cycle");
  chk_mv_no_powered: assert property (medium_voltage |=> !line_powered_self_test_ff)
    else $error("powered self-test on medium voltage");
  chk_lock_blocks: assert property (lock_status_ff && edit_inc |=> !edit_inc_ok_ff)
    else $error("edit passed while locked");
  chk_wrong_code: assert property (lock_status_ff && last_dig && (nxt_entry != code_ff)
                                   |=> lock_status_ff)
    else $error("wrong code unlocked");
  chk_event_newest: assert property (evt_push |=> (u_event_log.entry_ff[0] == $past(event_new)))
    else $error("event not in newest slot");

endmodule // starter_supervisor

//--- verif/link_master_model.sv
// Serial link master model: sends addressed requests to the block
`timescale 1ns/1ns
module link_master_model (
  // Clock
  input  wire logic  core_clk,
  // Request report
  output logic       rx_request_valid,
  output logic [7:0] rx_request_addr
);
  initial begin
    rx_request_valid = 1'b0;
    rx_request_addr  = 8'h5a;
  end
  // Between frames the address shows the inverse, so a stale match cannot pass
  task automatic send(input logic [7:0] addr, input int gap);
    repeat (gap) @(posedge core_clk);
    #1 rx_request_valid = 1'b1;
    rx_request_addr = addr;
    @(posedge core_clk);
    #1 rx_request_valid = 1'b0;
    rx_request_addr = ~addr;
  endtask
endmodule // link_master_model

//--- verif/tb_top.sv
// Self-checking bench for the starter supervisory logic
`timescale 1ns/1ns
module tb_top;
  localparam int SC = 10;
  logic core_clk, rst, fault_reset, maint_cmd_write, motor_idle, medium_voltage;
  logic lock_digit_valid, edit_inc, edit_dec, fault_valid, rx_request_valid;
  logic rx_request_accept_ff, link_timeout_fault_ff, controlled_stop_req_ff;
  logic [6:0] request_timeout_setting, event_rd_idx, event_fill_ff;
  logic [1:0] byte_framing_setting;
  logic [7:0] station_address_setting, fault_code, rx_request_addr, station_ff, pv, sta;
  logic [2:0] bit_rate_setting, time_date_format_setting;
  logic [3:0] maintenance_command_select, parameter_lock_code, starter_state;
  logic [3:0] fault_rd_idx, fault_fill_ff, code[4];
  logic [23:0] tod_hms, date_value;
  logic [15:0] fault_snapshot;
  starter_sup_pkg::framing_e   framing_ff;
  starter_sup_pkg::bit_rate_e  bit_rate_ff;
  starter_sup_pkg::maint_cmd_e maint_sel_ff;
  starter_sup_pkg::time_fmt_e  time_fmt_ff;
  starter_sup_pkg::fault_rec_s fault_rd_ff;
  starter_sup_pkg::event_rec_s event_rd_ff;
  logic clear_run_time_meter_ff, clear_energy_meters_ff, store_params_ff, load_params_ff;
  logic factory_defaults_ff, unpowered_self_test_ff, line_powered_self_test_ff, cmd_refused_ff;
  logic update_mode_indication_ff, remote_display_enable_ff, normal_operation_ff;
  logic lock_status_ff, edit_inc_ok_ff, edit_dec_ok_ff;
  int fails, checks_done, n;
  logic [31:0] seed = 32'h51;
  logic [7:0] fq[$], eq[$];

  // Short second so the watchdog runs in tens of cycles
  starter_supervisor #(.SEC_CYCLES(SC)) dut (.*);
  link_master_model master (.*);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int k = 1);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, want);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Model logs: newest at the front; the fault model drops its oldest when full
  task automatic note_fault(input logic [7:0] c);
    fq.push_front(c);
    eq.push_front(c);
    if (fq.size() > 9) fq.pop_back();
  endtask
  task automatic cmp_logs();
    chk("fault_fill", fault_fill_ff, fq.size());
    chk("event_fill", event_fill_ff, eq.size());
    foreach (fq[i]) begin
      fault_rd_idx = 4'(i);
      tick(2);
      chk("fault_code", fault_rd_ff.code, fq[i]);
    end
    foreach (eq[i]) begin
      event_rd_idx = 7'(i);
      tick(2);
      chk("event_code", event_rd_ff.code, eq[i]);
    end
  endtask
  task automatic cmd(input logic [3:0] c, s, input logic [7:0] want);
    maint_cmd_write = 1'b1;
    maintenance_command_select = c;
    tick();
    maint_cmd_write = 1'b0;
    // The selector holds the command for one cycle only, then the pulse follows
    chk("maint_sel", maint_sel_ff, s);
    tick();
    pv = {clear_run_time_meter_ff, clear_energy_meters_ff, store_params_ff, load_params_ff,
      factory_defaults_ff, unpowered_self_test_ff, line_powered_self_test_ff, cmd_refused_ff};
    chk("cmd_pulses", pv, want);
    chk("maint_sel_none", maint_sel_ff, 4'h0);
  endtask
  task automatic enter();
    foreach (code[i]) begin
      lock_digit_valid = 1'b1;
      parameter_lock_code = code[i];
      tick();
    end
    lock_digit_valid = 1'b0;
    tick(2);
  endtask
  task automatic edit(input logic ok);
    edit_inc = 1'b1;
    edit_dec = 1'b1;
    tick();
    edit_inc = 1'b0;
    edit_dec = 1'b0;
    pv[1:0] = {edit_inc_ok_ff, edit_dec_ok_ff};
    tick();
    pv[1:0] |= {edit_inc_ok_ff, edit_dec_ok_ff};
    chk("edit_ok", pv[1:0], {ok, ok});
  endtask

  initial begin
    rst = 1'b1;
    motor_idle = 1'b1;
    {fault_reset, maint_cmd_write, medium_voltage, lock_digit_valid, edit_inc, edit_dec,
      fault_valid, maintenance_command_select, parameter_lock_code, starter_state} = '0;
    {request_timeout_setting, byte_framing_setting, time_date_format_setting, fault_code,
      fault_snapshot, tod_hms, date_value, fault_rd_idx, event_rd_idx} = '0;
    station_address_setting = 8'h01;
    bit_rate_setting = 3'h4;
    tick(6);
    rst = 1'b0;
    tick();
    chk("station", station_ff, 8'h01);
    chk("rate", bit_rate_ff, 3'h4);
    chk("framing", framing_ff, 2'h0);
    chk("fmt", time_fmt_ff, 3'h0);
    chk("lock", lock_status_ff, 1'b0);
    for (int i = 0; i < 4; i++) begin
      pv = 8'(rnd());
      byte_framing_setting = 2'(i);
      bit_rate_setting = 3'(pv % 5);
      time_date_format_setting = 3'(pv % 6);
      tick(2);
      chk("framing", framing_ff, i);
      chk("rate", bit_rate_ff, pv % 5);
      chk("fmt", time_fmt_ff, pv % 6);
    end
    sta = 8'(rnd() % 247 + 1);
    station_address_setting = sta;
    tick(40);
    chk("no_watchdog", link_timeout_fault_ff, 1'b0);
    request_timeout_setting = 7'h02;
    master.send(sta, 0);
    n = 32'(rx_request_accept_ff);
    tick();
    chk("accept", n | rx_request_accept_ff, 1'b1);
    // A foreign address must not restart the count
    master.send(sta ^ 8'h80, 3);
    n = 5;
    while (!link_timeout_fault_ff && n < 60) begin
      tick();
      n++;
    end
    if (n >= 60) begin
      fails++;
      print_verdict();
    end
    chk("timeout_at", n >= 2 * SC - 1 && n <= 2 * SC + 2, 1'b1);
    chk("stop_req", controlled_stop_req_ff, 1'b1);
    note_fault(8'h52);
    request_timeout_setting = 7'h00;
    fault_reset = 1'b1;
    tick();
    fault_reset = 1'b0;
    tick();
    chk("fault_clear", link_timeout_fault_ff, 1'b0);
    repeat (10) begin
      fault_code = 8'(rnd());
      fault_snapshot = 16'(rnd());
      fault_valid = 1'b1;
      tick();
      note_fault(fault_code);
    end
    fault_valid = 1'b0;
    tod_hms = 24'(rnd());
    date_value = 24'(rnd());
    starter_state = 4'h3;
    eq.push_front(8'h83);
    tick(2);
    chk("event_rec", event_rd_ff, {8'h83, 4'h3, tod_hms, date_value});
    cmp_logs();
    foreach (code[i]) code[i] = 4'(rnd() % 10);
    edit(1'b1);
    enter();
    chk("lock_on", lock_status_ff, 1'b1);
    edit(1'b0);
    code[0] = 4'((code[0] + 1) % 10);
    enter();
    chk("lock_kept", lock_status_ff, 1'b1);
    code[0] = 4'((code[0] + 9) % 10);
    enter();
    chk("lock_off", lock_status_ff, 1'b0);
    for (int c = 1; c <= 8; c++)
      if (c != 3) cmd(4'(c), 4'(c), 8'h80 >> (c - 1 - (c > 3)));
    medium_voltage = 1'b1;
    cmd(4'h8, 4'h8, 8'h01);
    motor_idle = 1'b0;
    cmd(4'h3, 4'h3, 8'h01);
    motor_idle = 1'b1;
    cmd(4'h3, 4'h3, 8'h00);
    chk("update_mode", {update_mode_indication_ff, remote_display_enable_ff,
      normal_operation_ff}, 3'h4);
    cmd(4'h4, 4'h0, 8'h00);
    master.send(sta, 0);
    tick();
    chk("halted_link", rx_request_accept_ff, 1'b0);
    print_verdict();
  end
endmodule // tb_top
